/* uef_defs.vh */
// Constants for the endpoint FIFO and host control block
`ifndef UEF_DEFS_VH
`define UEF_DEFS_VH
`define UEF_NEP 8
`define UEF_EPW 3
`define UEF_ADRW 12
`define UEF_FAW 7
`define UEF_FRW 11
`define UEF_STW 16
`define UEF_ALIGN_LSB 3
// Register byte offsets (word index in bits 7:2)
`define UEF_A_SEL 8'h00
`define UEF_A_CFG 8'h04
`define UEF_A_FADDR 8'h08
`define UEF_A_CMD 8'h0c
`define UEF_A_FRAME 8'h10
`define UEF_A_STATUS 8'h14
`define UEF_A_STCLR 8'h18
`define UEF_A_MODE 8'h1c
`define UEF_A_IRQST 8'h20
`define UEF_A_IRQCLR 8'h24
`define UEF_A_IRQEN 8'h28
`define UEF_A_FOOT 8'h2c
// SEL fields: [2:0] endpoint, [3] direction (1 = IN)
`define UEF_SEL_DIR 3
// CFG fields: [11:0] start offset, [15:12] size code, [16] double buffer
`define UEF_CFG_SZ_LSB 12
`define UEF_CFG_DB 16
// CMD bits
`define UEF_CMD_FLUSH 0
`define UEF_CMD_ACK 1
`define UEF_CMD_TGLSET 2
`define UEF_CMD_TGLVAL 3
`define UEF_CMD_TGLCLR 4
// Interrupt events
`define UEF_IRQ_SOF 0
`define UEF_IRQ_RX 1
`define UEF_IRQ_W 2
`define UEF_ST_RXRDY 0
`endif

/* uef_ctrl.v */
// Endpoint FIFO placement, flush, frame capture and host endpoint control
// Functional notes
// - Endpoint zero FIFO is fixed; configuration writes for it are ignored
// - Each nonzero endpoint keeps readable IN and OUT start and size
// - Double buffered FIFO footprint is twice the selected size
// - Start value is an 8-byte aligned byte offset used directly
// - Flush discards the selected endpoint FIFO in host and device mode
// - Frame number of the latest start-of-frame is captured for reading
// - Host mode keeps a readable target address per endpoint and direction
// - Host mode holds a received packet until software acknowledges it
// - Host mode toggle force: zero selects DATA0, one selects DATA1
// - Forcing endpoint zero toggle ignores the direction selection
// - Host mode clears exactly the status bits given in the mask
// - Nonzero endpoint toggle reset to zero works in both modes
//
// Chosen here: the APB slave port and the register addresses.
`include "uef_defs.vh"
`default_nettype none
module uef_ctrl (
  input wire ref_clk,
  input wire nrst,
  input wire clkEn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire sofValid,
  input wire [`UEF_FRW-1:0] sofFrame,
  input wire rxValid,
  input wire [`UEF_EPW-1:0] rxEp,
  input wire [`UEF_STW-1:0] stSet,
  input wire [`UEF_EPW-1:0] stSetEp,
  input wire [`UEF_EPW-1:0] lookEp,
  input wire lookDirIn,
  output reg [`UEF_ADRW-1:0] lookStart,
  output reg [`UEF_ADRW:0] lookFoot,
  output reg [`UEF_FAW-1:0] lookAddr,
  output reg lookToggle,
  output reg lookHeld,
  output reg flushPulse,
  output reg [`UEF_EPW-1:0] flushEp,
  output reg flushDirIn,
  output reg hostMode,
  output wire irq
);
  reg [`UEF_ADRW-1:0] startOut [0:`UEF_NEP-1];
  reg [`UEF_ADRW-1:0] startIn [0:`UEF_NEP-1];
  reg [4:0] sizeOut [0:`UEF_NEP-1];
  reg [4:0] sizeIn [0:`UEF_NEP-1];
  reg [`UEF_FAW-1:0] addrOut [0:`UEF_NEP-1];
  reg [`UEF_FAW-1:0] addrIn [0:`UEF_NEP-1];
  reg [`UEF_STW-1:0] status [0:`UEF_NEP-1];
  reg [`UEF_NEP-1:0] tglOut_r;
  reg [`UEF_NEP-1:0] tglIn_r;
  reg [`UEF_NEP-1:0] held_r;
  reg [`UEF_EPW-1:0] selEp_r;
  reg selDirIn_r;
  reg [`UEF_FRW-1:0] frame_r;
  reg [`UEF_IRQ_W-1:0] irqSt_r;
  reg [`UEF_IRQ_W-1:0] irqEn_r;
  wire wrEn;
  wire epZero;
  wire [`UEF_IRQ_W-1:0] irqEvt;
  wire [`UEF_IRQ_W-1:0] irqClr;
  integer i;

  // Footprint in bytes: 8 << code, doubled when double buffered
  function [`UEF_ADRW:0] footprint;
    input [4:0] sz;
    begin
      footprint = {{`UEF_ADRW{1'b0}}, 1'b1} << (sz[3:0] + 4'h3);
      if (sz[4])
        footprint = {footprint[`UEF_ADRW-1:0], 1'b0};
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = clkEn & psel & penable & pwrite;
  assign epZero = (selEp_r == {`UEF_EPW{1'b0}});
  assign irqEvt = {rxValid, sofValid};
  assign irqClr = (wrEn && paddr == `UEF_A_IRQCLR) ?
    pwdata[`UEF_IRQ_W-1:0] : {`UEF_IRQ_W{1'b0}};
  assign irq = |(irqSt_r & irqEn_r);

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < `UEF_NEP; i = i + 1)
      begin
        startOut[i] <= {`UEF_ADRW{1'b0}};
        startIn[i] <= {`UEF_ADRW{1'b0}};
        sizeOut[i] <= 5'h00;
        sizeIn[i] <= 5'h00;
        addrOut[i] <= {`UEF_FAW{1'b0}};
        addrIn[i] <= {`UEF_FAW{1'b0}};
        status[i] <= {`UEF_STW{1'b0}};
      end
      tglOut_r <= {`UEF_NEP{1'b0}};
      tglIn_r <= {`UEF_NEP{1'b0}};
      held_r <= {`UEF_NEP{1'b0}};
      selEp_r <= {`UEF_EPW{1'b0}};
      selDirIn_r <= 1'b0;
      frame_r <= {`UEF_FRW{1'b0}};
      irqSt_r <= {`UEF_IRQ_W{1'b0}};
      irqEn_r <= {`UEF_IRQ_W{1'b0}};
      hostMode <= 1'b0;
      flushPulse <= 1'b0;
      flushEp <= {`UEF_EPW{1'b0}};
      flushDirIn <= 1'b0;
    end
    else if (clkEn)
    begin
      flushPulse <= 1'b0;
      if (sofValid)
        frame_r <= sofFrame;
      irqSt_r <= (irqSt_r & ~irqClr) | irqEvt;
      if (wrEn)
      begin
        case (paddr)
          `UEF_A_SEL:
          begin
            selEp_r <= pwdata[`UEF_EPW-1:0];
            selDirIn_r <= pwdata[`UEF_SEL_DIR];
          end
          `UEF_A_CFG:
            if (!epZero)
            begin
              if (selDirIn_r)
              begin
                startIn[selEp_r] <= {pwdata[`UEF_ADRW-1:`UEF_ALIGN_LSB],
                  3'h0};
                sizeIn[selEp_r] <= {pwdata[`UEF_CFG_DB],
                  pwdata[`UEF_CFG_SZ_LSB+3:`UEF_CFG_SZ_LSB]};
              end
              else
              begin
                startOut[selEp_r] <= {pwdata[`UEF_ADRW-1:`UEF_ALIGN_LSB],
                  3'h0};
                sizeOut[selEp_r] <= {pwdata[`UEF_CFG_DB],
                  pwdata[`UEF_CFG_SZ_LSB+3:`UEF_CFG_SZ_LSB]};
              end
            end
          `UEF_A_FADDR:
            if (hostMode)
            begin
              if (selDirIn_r)
                addrIn[selEp_r] <= pwdata[`UEF_FAW-1:0];
              else
                addrOut[selEp_r] <= pwdata[`UEF_FAW-1:0];
            end
          `UEF_A_MODE:
            hostMode <= pwdata[0];
          `UEF_A_IRQEN:
            irqEn_r <= pwdata[`UEF_IRQ_W-1:0];
          `UEF_A_CMD:
          begin
            if (pwdata[`UEF_CMD_FLUSH])
            begin
              flushPulse <= 1'b1;
              flushEp <= selEp_r;
              flushDirIn <= selDirIn_r;
            end
            if (pwdata[`UEF_CMD_TGLSET] && hostMode)
            begin
              if (epZero)
              begin
                tglIn_r[0] <= pwdata[`UEF_CMD_TGLVAL];
                tglOut_r[0] <= pwdata[`UEF_CMD_TGLVAL];
              end
              else if (selDirIn_r)
                tglIn_r[selEp_r] <= pwdata[`UEF_CMD_TGLVAL];
              else
                tglOut_r[selEp_r] <= pwdata[`UEF_CMD_TGLVAL];
            end
            else if (pwdata[`UEF_CMD_TGLCLR] && !epZero)
            begin
              if (selDirIn_r)
                tglIn_r[selEp_r] <= 1'b0;
              else
                tglOut_r[selEp_r] <= 1'b0;
            end
          end
          default:
          begin
          end
        endcase
      end
      // Packet held until ack; a new arrival in the ack cycle wins
      for (i = 0; i < `UEF_NEP; i = i + 1)
      begin
        if (wrEn && paddr == `UEF_A_CMD && pwdata[`UEF_CMD_ACK] &&
            hostMode && selEp_r == i[`UEF_EPW-1:0])
        begin
          held_r[i] <= 1'b0;
          status[i][`UEF_ST_RXRDY] <= 1'b0;
        end
        if (wrEn && paddr == `UEF_A_STCLR && hostMode &&
            selEp_r == i[`UEF_EPW-1:0])
          status[i] <= status[i] & ~pwdata[`UEF_STW-1:0];
        if (stSetEp == i[`UEF_EPW-1:0] && |stSet)
          status[i] <= (status[i] &
            ~((wrEn && paddr == `UEF_A_STCLR && hostMode &&
            selEp_r == i[`UEF_EPW-1:0]) ? pwdata[`UEF_STW-1:0] :
            {`UEF_STW{1'b0}})) | stSet;
        // Flush clear comes first so a packet arriving with it is kept
        if (flushPulse && flushEp == i[`UEF_EPW-1:0])
          held_r[i] <= 1'b0;
        if (rxValid && rxEp == i[`UEF_EPW-1:0])
        begin
          held_r[i] <= 1'b1;
          status[i][`UEF_ST_RXRDY] <= 1'b1;
        end
      end
    end
  end

  // Lookup port for the packet engine
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lookStart <= {`UEF_ADRW{1'b0}};
      lookFoot <= {(`UEF_ADRW+1){1'b0}};
      lookAddr <= {`UEF_FAW{1'b0}};
      lookToggle <= 1'b0;
      lookHeld <= 1'b0;
    end
    else if (clkEn)
    begin
      lookStart <= lookDirIn ? startIn[lookEp] : startOut[lookEp];
      lookFoot <= footprint(lookDirIn ? sizeIn[lookEp] : sizeOut[lookEp]);
      lookAddr <= lookDirIn ? addrIn[lookEp] : addrOut[lookEp];
      lookToggle <= (lookEp == {`UEF_EPW{1'b0}}) ? tglIn_r[0] :
        (lookDirIn ? tglIn_r[lookEp] : tglOut_r[lookEp]);
      lookHeld <= held_r[lookEp];
    end
  end

  always @*
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      `UEF_A_SEL:
        prdata = {28'h0000000, selDirIn_r, selEp_r};
      `UEF_A_CFG:
        prdata = selDirIn_r ?
          {15'h0000, sizeIn[selEp_r], startIn[selEp_r]} :
          {15'h0000, sizeOut[selEp_r], startOut[selEp_r]};
      `UEF_A_FADDR:
        prdata = {25'h0000000, selDirIn_r ? addrIn[selEp_r] :
          addrOut[selEp_r]};
      `UEF_A_CMD:
        prdata = {27'h0000000, 1'b0, selDirIn_r ? tglIn_r[selEp_r] :
          tglOut_r[selEp_r], 2'h0, held_r[selEp_r]};
      `UEF_A_FRAME:
        prdata = {21'h000000, frame_r};
      `UEF_A_STATUS:
        prdata = {16'h0000, status[selEp_r]};
      `UEF_A_MODE:
        prdata = {31'h00000000, hostMode};
      `UEF_A_IRQST:
        prdata = {30'h00000000, irqSt_r};
      `UEF_A_IRQEN:
        prdata = {30'h00000000, irqEn_r};
      `UEF_A_FOOT:
        prdata = {19'h00000, footprint(selDirIn_r ? sizeIn[selEp_r] :
          sizeOut[selEp_r])};
      default:
        prdata = 32'h0000_0000;
    endcase
  end
endmodule // uef_ctrl
`default_nettype wire

/* uef_ctrl_props.sv */
// Assertion checker for the endpoint control block
`include "uef_defs.vh"
`default_nettype none
module uef_ctrl_props (
  input wire logic ref_clk, nrst, clkEn, psel, penable, pwrite, sofValid,
  input wire logic rxValid, lookDirIn, lookToggle, flushPulse, flushDirIn,
  input wire logic hostMode, irq,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [10:0] sofFrame,
  input wire logic [2:0] lookEp, flushEp,
  input wire logic [11:0] lookStart
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] selR;
  logic [10:0] frR;
  logic tvR;
  wire wr = psel && penable && pwrite && clkEn;
  wire wCmd = wr && paddr == `UEF_A_CMD;
  wire ev = clkEn && (sofValid || rxValid || wr);
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      selR <= 4'h0;
    else if (wr && paddr == `UEF_A_SEL)
      selR <= pwdata[3:0];
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      frR <= 11'h0;
    else if (clkEn && sofValid)
      frR <= sofFrame;
  always @(posedge ref_clk or negedge nrst)
    if (!nrst)
      tvR <= 1'h0;
    else if (wCmd)
      tvR <= pwdata[3];
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  sequence s_look;
    clkEn && lookEp == selR[2:0] && (selR[2:0] == 3'h0 || lookDirIn == selR[3]);
  endsequence
  property p_tgl;
    wCmd && pwdata[2] && hostMode ##1 s_look |=> lookToggle == tvR;
  endproperty
  a_tgl: assert property (p_tgl) else $error("forced toggle wrong");
  property p_tclr;
    wCmd && pwdata[4] && !pwdata[2] && selR[2:0] != 3'h0 ##1 s_look |=> !lookToggle;
  endproperty
  a_tclr: assert property (p_tclr) else $error("toggle not cleared");
  property p_flush;
    wCmd && pwdata[0] |=> flushPulse && flushEp == selR[2:0] && flushDirIn == selR[3];
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse wrong");
  property p_noflush;
    clkEn && !(wCmd && pwdata[0]) |=> !flushPulse;
  endproperty
  a_noflush: assert property (p_noflush) else $error("stray flush");
  property p_frame;
    psel && penable && !pwrite && paddr == `UEF_A_FRAME |-> prdata[10:0] == frR;
  endproperty
  a_frame: assert property (p_frame) else $error("frame read wrong");
  property p_mode;
    wr && paddr == `UEF_A_MODE |=> hostMode == $past(pwdata[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not taken");
  property p_ep0;
    clkEn && lookEp == 3'h0 ##1 clkEn && lookEp == 3'h0 |=> $stable(lookStart);
  endproperty
  a_ep0: assert property (p_ep0) else $error("endpoint zero moved");
  property p_irq;
    $rose(irq) |-> $past(ev);
  endproperty
  a_irq: assert property (p_irq) else $error("irq rose with no cause");
endmodule // uef_ctrl_props
bind uef_ctrl uef_ctrl_props u_uef_ctrl_props (.*);
`default_nettype wire

/* uef_bus.sv */
// Bus partner model: start-of-frame tokens and received packets
`default_nettype none
module uef_bus (
  input wire logic ref_clk,
  output logic sofValid,
  output logic [10:0] sofFrame,
  output logic rxValid,
  output logic [2:0] rxEp,
  output logic [15:0] stSet,
  output logic [2:0] stSetEp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    sofValid = 1'h0;
    sofFrame = 11'h0;
    rxValid = 1'h0;
    rxEp = 3'h0;
    stSet = 16'h0;
    stSetEp = 3'h0;
  end
  task sof(input logic [10:0] f);
    @(posedge ref_clk);
    sofValid <= 1'h1;
    sofFrame <= f;
    @(posedge ref_clk);
    sofValid <= 1'h0;
    sofFrame <= ~f;
  endtask
  task rx(input logic [2:0] e, input logic [15:0] s);
    @(posedge ref_clk);
    rxValid <= 1'h1;
    rxEp <= e;
    stSet <= s;
    stSetEp <= e;
    @(posedge ref_clk);
    rxValid <= 1'h0;
    rxEp <= ~e;
    stSet <= 16'h0;
    stSetEp <= ~e;
  endtask
endmodule // uef_bus
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the endpoint control block
`include "uef_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'h0, nrst = 1'h0, clkEn = 1'h1, lookDirIn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, r, e0;
  logic [2:0] lookEp = 3'h0;
  wire logic sofValid, rxValid, pready, pslverr, lookToggle, lookHeld;
  wire logic flushPulse, flushDirIn, hostMode, irq;
  wire logic [10:0] sofFrame;
  wire logic [2:0] rxEp, stSetEp, flushEp;
  wire logic [15:0] stSet;
  wire logic [31:0] prdata;
  wire logic [11:0] lookStart;
  wire logic [12:0] lookFoot;
  wire logic [6:0] lookAddr;
  int failures = 0, num_checks = 0, c;
  uef_ctrl u_uef_ctrl (.*);
  uef_bus u_uef_bus (.*);
  always #50 ref_clk = ~ref_clk;
  task chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    @(posedge ref_clk);
    while (pready !== 1'h1)
      @(posedge ref_clk);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'h0, a, 32'h0);
    chk(r & m, e);
    chk(pslverr, 32'h0);
  endtask
  task look(input logic [2:0] e, input logic d);
    lookEp <= e;
    lookDirIn <= d;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task t_cfg;
    wr(`UEF_A_SEL, 32'hb);
    wr(`UEF_A_CFG, 32'h11048);
    wr(`UEF_A_SEL, 32'h3);
    for (c = 0; c < 4; c++)
    begin
      wr(`UEF_A_CFG, {c[0], c[3:0], 12'h100});
      rdc(`UEF_A_FOOT, 32'hffffffff, (32'h8 << c) << c[0]);
    end
    rdc(`UEF_A_CFG, 32'hffffffff, 32'h13100);
    wr(`UEF_A_SEL, 32'hb);
    rdc(`UEF_A_CFG, 32'hffffffff, 32'h11048);
    look(3'h3, 1'h1);
    chk(lookStart, 32'h48);
    chk(lookFoot, 32'h20);
    wr(`UEF_A_SEL, 32'h0);
    apb(1'h0, `UEF_A_CFG, 32'h0);
    e0 = r;
    wr(`UEF_A_CFG, 32'h11048);
    rdc(`UEF_A_CFG, 32'hffffffff, e0);
    look(3'h0, 1'h1);
  endtask
  task t_flush;
    for (c = 0; c < 2; c++)
    begin
      wr(`UEF_A_MODE, c);
      wr(`UEF_A_SEL, {c[0], c[0], 2'h1});
      wr(`UEF_A_CMD, 32'h1);
      #1 chk({flushPulse, flushDirIn, flushEp}, {1'h1, c[0], c[0], 2'h1});
    end
  endtask
  task t_frame;
    u_uef_bus.sof(11'h5a3);
    rdc(`UEF_A_FRAME, 32'hffffffff, 32'h5a3);
    u_uef_bus.sof(11'h7ff);
    rdc(`UEF_A_FRAME, 32'hffffffff, 32'h7ff);
  endtask
  task t_addr;
    wr(`UEF_A_MODE, 32'h0);
    wr(`UEF_A_SEL, 32'h9);
    wr(`UEF_A_FADDR, 32'h55);
    rdc(`UEF_A_FADDR, 32'hffffffff, 32'h0);
    wr(`UEF_A_MODE, 32'h1);
    wr(`UEF_A_FADDR, 32'h7f);
    wr(`UEF_A_SEL, 32'h1);
    wr(`UEF_A_FADDR, 32'h2a);
    rdc(`UEF_A_FADDR, 32'hffffffff, 32'h2a);
    look(3'h1, 1'h1);
    chk(lookAddr, 32'h7f);
  endtask
  task t_rx;
    wr(`UEF_A_IRQCLR, 32'h3);
    wr(`UEF_A_IRQEN, 32'h0);
    u_uef_bus.rx(3'h4, 16'h8001);
    wr(`UEF_A_SEL, 32'hc);
    rdc(`UEF_A_IRQST, 32'h3, 32'h2);
    chk(irq, 32'h0);
    wr(`UEF_A_IRQEN, 32'h2);
    #1 chk(irq, 32'h1);
    wr(`UEF_A_IRQCLR, 32'h2);
    #1 chk(irq, 32'h0);
    wr(`UEF_A_STCLR, 32'h8000);
    rdc(`UEF_A_STATUS, 32'hffff, 32'h1);
    rdc(`UEF_A_CMD, 32'h1, 32'h1);
    look(3'h4, 1'h1);
    chk(lookHeld, 32'h1);
    wr(`UEF_A_CMD, 32'h2);
    rdc(`UEF_A_CMD, 32'h1, 32'h0);
    look(3'h4, 1'h1);
    chk(lookHeld, 32'h0);
    clkEn <= 1'h0;
    wr(`UEF_A_MODE, 32'h0);
    clkEn <= 1'h1;
    rdc(`UEF_A_MODE, 32'h1, 32'h1);
  endtask
  task t_tgl;
    lookEp <= 3'h6;
    lookDirIn <= 1'h0;
    wr(`UEF_A_SEL, 32'h6);
    wr(`UEF_A_CMD, 32'hc);
    rdc(`UEF_A_CMD, 32'h8, 32'h8);
    wr(`UEF_A_SEL, 32'h0);
    wr(`UEF_A_CMD, 32'hc);
    wr(`UEF_A_SEL, 32'h8);
    rdc(`UEF_A_CMD, 32'h8, 32'h8);
    wr(`UEF_A_CMD, 32'h4);
    rdc(`UEF_A_CMD, 32'h8, 32'h0);
    wr(`UEF_A_SEL, 32'h6);
    wr(`UEF_A_MODE, 32'h0);
    wr(`UEF_A_CMD, 32'h10);
    rdc(`UEF_A_CMD, 32'h8, 32'h0);
    wr(`UEF_A_CMD, 32'hc);
    rdc(`UEF_A_CMD, 32'h8, 32'h0);
  endtask
  task end_of_test;
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'h1;
    t_cfg;
    t_flush;
    t_frame;
    t_addr;
    t_rx;
    t_tgl;
    end_of_test;
  end
  initial
  begin
    #500000;
    failures++;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
